// ===== core/mtw_cfg.svh
`ifndef MTW_CFG_SVH
`define MTW_CFG_SVH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define MTW_ADDR_CTRL 8'hE1
`define MTW_ADDR_DATA 8'hE2
`define MTW_CTRL_RESET 8'h04
`define MTW_DATA_RESET 8'h00

// -----------------------------------------------------------------------------
// Bus clock: bit length in system clocks for each rate code, and its quarter
// -----------------------------------------------------------------------------
`define MTW_RATIO_0 9'd32
`define MTW_RATIO_1 9'd64
`define MTW_RATIO_2 9'd128
`define MTW_RATIO_3 9'd256
`define MTW_QUARTER(r) (r / 9'd4)

// -----------------------------------------------------------------------------
// Receive buffer depth and last bit index of a byte
// -----------------------------------------------------------------------------
`define MTW_FIFO_DEPTH 8
`define MTW_LAST_BIT 4'h7

`endif

// ===== core/mtw_pkg.sv
`default_nettype none
package mtw_pkg;
  `include "mtw_cfg.svh"

  typedef struct packed {
    logic controller_enable;
    logic ack_out_select;
    logic transfer_done_flag;
    logic ack_in_status;
    logic start_control;
    logic stop_control;
    logic [1:0] bus_clock_rate;
  } mtw_ctrl_type;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } mtw_sfr_req_type;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } mtw_pins_type;

  typedef enum logic [5:0] {
    MTW_IDLE = 6'h01,
    MTW_START = 6'h02,
    MTW_BIT = 6'h04,
    MTW_ACK = 6'h08,
    MTW_WAIT = 6'h10,
    MTW_STOP = 6'h20
  } mtw_state_type;
endpackage
`default_nettype wire

// ===== core/mtw_fifo.sv
`default_nettype none
`include "mtw_cfg.svh"
module mtw_fifo import mtw_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `MTW_FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  always_comb begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    next_wptr = push ? AW'(wptr + 1'b1) : wptr;
    next_rptr = pop ? AW'(rptr + 1'b1) : rptr;
    next_count = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wptr] <= i_in_data;
    end
  end

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rptr];
endmodule
`default_nettype wire

// ===== core/mtw_ctrl.sv
// Contract
// RULE1 - Software loads address byte, clears stop, then sets start to begin.
// RULE2 - After START, send seven address bits then the direction bit.
// RULE3 - Set done flag when the address byte has been shifted out.
// RULE4 - Set done flag at the end of each data byte sent.
// RULE5 - Data register write between START and STOP launches a transmit byte.
// RULE6 - Data register read between START and STOP launches a receive byte.
// RULE7 - First read after the address phase returns no slave data.
// RULE8 - Read after a receive returns the received byte and starts the next.
// RULE9 - Software waits for and clears the done flag before each next access.
// RULE10 - Software keeps start set during the transaction; clearing it ends it.
// RULE11 - Software clears start and sets stop; controller then drives STOP.
// RULE12 - Software keeps start low over one bus clock period between transactions.
// RULE13 - While receiving, ack select zero returns ACK, one returns NACK.
// RULE14 - Bus clock is system clock divided by the two-bit rate field ratio.
// RULE15 - Lines are open drain; slave ACK sampled on ninth clock, readable.
`default_nettype none
`include "mtw_cfg.svh"
module mtw_ctrl import mtw_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire mtw_sfr_req_type i_sfr,
  output logic [7:0] o_sfr_rdata,
  output logic o_transfer_done,
  input wire logic i_bus_clock_line,
  output logic o_bus_clock_line,
  output logic o_bus_clock_line_oe,
  input wire logic i_bus_data_line,
  output logic o_bus_data_line,
  output logic o_bus_data_line_oe
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  mtw_state_type st, next_st;
  mtw_ctrl_type ctrl, next_ctrl;
  mtw_pins_type pins, next_pins;
  logic [7:0] shift, next_shift, rdata, next_rdata;
  logic [1:0] phase, next_phase;
  logic [3:0] bitn, next_bitn;
  // Seven bits, so that the slowest rate's quarter of 64 clocks does not wrap to zero.
  logic [6:0] div, next_div, quarter;
  logic rx_mode, next_rx_mode, addr_phase, next_addr_phase, start_q;
  logic scl_s1, scl_s2, sda_s1, sda_s2, line_lvl;
  logic tick, adv, wr_ctrl, wr_data, rd_data, push_need;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;

  // ---------------------------------------------------------------------------
  // Pin synchronisers and received-byte buffer
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      {scl_s1, scl_s2, sda_s1, sda_s2} <= 4'hF;
      line_lvl <= 1'b0;
    end else begin
      {scl_s1, scl_s2} <= {i_bus_clock_line, scl_s1};
      {sda_s1, sda_s2} <= {i_bus_data_line, sda_s1};
      line_lvl <= 1'b0;
    end
  end

  // The engine will not finish a received byte while the buffer is full.
  mtw_fifo #(.WIDTH(8), .DEPTH(`MTW_FIFO_DEPTH)) u_rx_fifo (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(push_need),
    .o_in_ready(fifo_in_ready),
    .i_in_data(shift),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(rd_data),
    .o_out_data(fifo_out_data)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    unique case (ctrl.bus_clock_rate) // see RULE14
      2'h0: quarter = 7'(`MTW_QUARTER(`MTW_RATIO_0));
      2'h1: quarter = 7'(`MTW_QUARTER(`MTW_RATIO_1));
      2'h2: quarter = 7'(`MTW_QUARTER(`MTW_RATIO_2));
      2'h3: quarter = 7'(`MTW_QUARTER(`MTW_RATIO_3));
    endcase
    wr_ctrl = i_sfr.wr && (i_sfr.addr == `MTW_ADDR_CTRL);
    wr_data = i_sfr.wr && (i_sfr.addr == `MTW_ADDR_DATA);
    rd_data = i_sfr.rd && (i_sfr.addr == `MTW_ADDR_DATA);
    tick = (div == 7'h00);
    push_need = tick && (st == MTW_ACK) && (phase == 2'h3) && rx_mode && !addr_phase;
    adv = tick && !(push_need && !fifo_in_ready);
    next_st = st;
    next_ctrl = ctrl;
    next_pins = pins;
    next_shift = shift;
    next_phase = phase;
    next_bitn = bitn;
    next_rx_mode = rx_mode;
    next_addr_phase = addr_phase;
    next_div = (st == MTW_IDLE || st == MTW_WAIT) ? 7'(quarter - 7'h01) : div;
    if (tick && !adv) begin
      next_div = div;
    end else if (st != MTW_IDLE && st != MTW_WAIT) begin
      next_div = tick ? 7'(quarter - 7'h01) : 7'(div - 7'h01);
    end
    if (adv && st != MTW_IDLE && st != MTW_WAIT) begin
      next_phase = 2'(phase + 2'h1);
    end
    next_rdata = 8'h00;
    if (i_sfr.rd && i_sfr.addr == `MTW_ADDR_CTRL) begin
      next_rdata = ctrl;
    end else if (rd_data) begin
      next_rdata = fifo_out_valid ? fifo_out_data : shift; // see RULE7 see RULE8
    end
    if (wr_ctrl) begin
      next_ctrl.controller_enable = i_sfr.wdata[7];
      next_ctrl.ack_out_select = i_sfr.wdata[6];
      next_ctrl.transfer_done_flag = ctrl.transfer_done_flag & i_sfr.wdata[5];
      next_ctrl.start_control = i_sfr.wdata[3];
      next_ctrl.stop_control = i_sfr.wdata[2];
      next_ctrl.bus_clock_rate = i_sfr.wdata[1:0];
    end
    if (wr_data) begin
      next_shift = i_sfr.wdata;
    end
    unique case (st)
      MTW_IDLE: begin
        next_pins = '0;
        next_phase = 2'h0;
        if (ctrl.controller_enable && ctrl.start_control && !start_q) begin
          next_st = MTW_START; // see RULE1
        end
      end
      MTW_START: begin
        if (adv) begin
          if (phase == 2'h1) next_pins.sda_oe = 1'b1;
          if (phase == 2'h2) next_pins.scl_oe = 1'b1;
          if (phase == 2'h3) begin
            next_st = MTW_BIT; // see RULE2
            next_bitn = 4'h0;
            next_addr_phase = 1'b1;
            next_rx_mode = shift[0];
          end
        end
      end
      MTW_BIT: begin
        if (adv) begin
          unique case (phase)
            2'h0: next_pins.sda_oe = (rx_mode && !addr_phase) ? 1'b0 : !shift[7]; // see RULE2
            2'h1: next_pins.scl_oe = 1'b0;
            2'h2: next_shift = {shift[6:0], sda_s2};
            2'h3: begin
              next_pins.scl_oe = 1'b1;
              next_bitn = 4'(bitn + 4'h1);
              if (bitn == `MTW_LAST_BIT) next_st = MTW_ACK;
            end
          endcase
        end
      end
      MTW_ACK: begin
        if (adv) begin
          unique case (phase)
            2'h0: next_pins.sda_oe = (rx_mode && !addr_phase) && !ctrl.ack_out_select; // see RULE13
            2'h1: next_pins.scl_oe = 1'b0;
            2'h2: if (!(rx_mode && !addr_phase)) next_ctrl.ack_in_status = sda_s2; // see RULE15
            2'h3: begin
              next_pins.scl_oe = 1'b1;
              next_ctrl.transfer_done_flag = 1'b1; // see RULE3 see RULE4
              next_addr_phase = 1'b0;
              next_st = MTW_WAIT;
            end
          endcase
        end
      end
      MTW_WAIT: begin
        next_pins.sda_oe = 1'b0;
        next_phase = 2'h0;
        next_bitn = 4'h0;
        if (!ctrl.start_control) begin
          next_st = MTW_STOP; // see RULE11
        end else if (wr_data && !rx_mode) begin
          next_st = MTW_BIT; // see RULE5
        end else if (rd_data && rx_mode) begin
          next_st = MTW_BIT; // see RULE6
        end
      end
      MTW_STOP: begin
        if (adv) begin
          if (phase == 2'h0) next_pins = '{scl_oe: 1'b1, sda_oe: 1'b1};
          if (phase == 2'h1) next_pins.scl_oe = 1'b0;
          if (phase == 2'h2) next_pins.sda_oe = 1'b0; // see RULE11
          if (phase == 2'h3) next_st = MTW_IDLE;
        end
      end
    endcase
    if (!ctrl.controller_enable) begin
      next_st = MTW_IDLE;
      next_pins = '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st <= MTW_IDLE;
      ctrl <= `MTW_CTRL_RESET;
      pins <= '0;
      shift <= `MTW_DATA_RESET;
      rdata <= 8'h00;
      phase <= 2'h0;
      bitn <= 4'h0;
      div <= 7'h00;
      rx_mode <= 1'b0;
      addr_phase <= 1'b0;
      start_q <= 1'b0;
    end else begin
      st <= next_st;
      ctrl <= next_ctrl;
      pins <= next_pins;
      shift <= next_shift;
      rdata <= next_rdata;
      phase <= next_phase;
      bitn <= next_bitn;
      div <= next_div;
      rx_mode <= next_rx_mode;
      addr_phase <= next_addr_phase;
      start_q <= ctrl.start_control;
    end
  end

  assign o_sfr_rdata = rdata;
  assign o_transfer_done = ctrl.transfer_done_flag;
  assign o_bus_clock_line = line_lvl;
  assign o_bus_data_line = line_lvl;
  assign o_bus_clock_line_oe = pins.scl_oe; // see RULE15
  assign o_bus_data_line_oe = pins.sda_oe;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  AST_START_LAUNCH: assert property ( // see RULE1
    st == MTW_IDLE && ctrl.controller_enable && ctrl.start_control && !start_q
    |=> st == MTW_START) else $error("start request not taken");
  AST_ADDR_BIT: assert property ( // see RULE2
    st == MTW_BIT && addr_phase && adv && phase == 2'h0
    |=> pins.sda_oe == !$past(shift[7])) else $error("address bit driven wrong");
  AST_DONE_SET: assert property ( // see RULE3
    st == MTW_ACK && adv && phase == 2'h3 |=> ctrl.transfer_done_flag && st == MTW_WAIT)
    else $error("done flag not set after byte");
  AST_WRITE_LAUNCH: assert property ( // see RULE5
    st == MTW_WAIT && ctrl.start_control && wr_data && !rx_mode
    |=> st == MTW_BIT && shift == $past(i_sfr.wdata)) else $error("write did not launch");
  AST_READ_LAUNCH: assert property ( // see RULE6
    st == MTW_WAIT && ctrl.start_control && rd_data && rx_mode |=> st == MTW_BIT)
    else $error("read did not launch");
  AST_READ_DATA: assert property ( // see RULE8
    rd_data && fifo_out_valid |=> o_sfr_rdata == $past(fifo_out_data))
    else $error("read returned wrong byte");
  AST_RX_ACK: assert property ( // see RULE13
    st == MTW_ACK && rx_mode && !addr_phase && phase == 2'h1
    |-> pins.sda_oe == !ctrl.ack_out_select) else $error("ack select not honoured");
  AST_RATE0: assert property ( // see RULE14
    tick && adv && st == MTW_BIT && ctrl.bus_clock_rate == 2'h0 |=> !tick [*7] ##1 tick)
    else $error("quarter period wrong");
  AST_STOP_EDGE: assert property ( // see RULE11
    st == MTW_STOP && $fell(pins.sda_oe) |-> !pins.scl_oe) else $error("stop edge without clock high");
  AST_ACK_IN: assert property ( // see RULE15
    st == MTW_ACK && !rx_mode && adv && phase == 2'h2 |=> ctrl.ack_in_status == $past(sda_s2))
    else $error("ack not captured");

  // Without clock stretching the sensed clock line only confirms that the pull-down works.
  AST_SCL_SENSE: assert property ( // see RULE15
    $rose(pins.scl_oe) |-> ##2 !scl_s2) else $error("clock line not pulled low");

  COV_TX_BYTE: cover property (st == MTW_WAIT && !rx_mode && wr_data);
  COV_RX_BYTE: cover property (push_need && fifo_in_ready);
  COV_STOP: cover property (st == MTW_STOP ##1 st == MTW_IDLE);
  COV_NACK_IN: cover property (st == MTW_WAIT && ctrl.ack_in_status);
endmodule
`default_nettype wire

// ===== test/mtw_slave_model.sv
`default_nettype none
// -----------------------------------------------------------------------------
// Two-wire slave that answers one address; the lines idle high through pull-ups
// -----------------------------------------------------------------------------
module mtw_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  output logic [7:0] o_last_rx,
  output logic o_master_ack,
  output logic o_stop_seen,
  output logic o_addr_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tbl [3] = '{8'h25, 8'hA6, 8'h3C};
  logic [7:0] sh = 8'h00;
  logic [7:0] txb = 8'hFF;
  logic rd = 1'b0;
  logic sel = 1'b0;
  logic aph = 1'b0;
  int bitn = 0;
  int idx = 0;
  initial begin
    o_sda_oe = 1'b0;
    o_last_rx = 8'h00;
    o_master_ack = 1'b1;
    o_stop_seen = 1'b0;
    o_addr_ack = 1'b0;
  end
  always @(negedge i_sda) begin
    if (i_scl) begin
      bitn = 0;
      aph = 1'b1;
      o_stop_seen = 1'b0;
    end
  end
  always @(posedge i_sda) begin
    if (i_scl) o_stop_seen = 1'b1;
  end
  always @(posedge i_scl) begin
    if (bitn < 8) sh = {sh[6:0], i_sda};
    else o_master_ack = i_sda;
    bitn++;
  end
  // Data only changes while the clock line is low, so no false START or STOP appears.
  always @(negedge i_scl) begin
    if (bitn == 8) begin
      if (aph) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
        o_addr_ack = sel;
      end else if (!rd) o_last_rx = sh;
      o_sda_oe = sel && (aph || !rd);
    end else if (bitn == 9) begin
      bitn = 0;
      if (rd && sel && (aph || !o_master_ack)) begin
        txb = tbl[idx];
        idx++;
      end else txb = 8'hFF;
      aph = 1'b0;
      o_sda_oe = rd && sel && !txb[7];
    end else if (rd && sel && !aph) o_sda_oe = !txb[7 - bitn];
  end
endmodule
`default_nettype wire

// ===== test/test_master_two_wire_controller.sv
`default_nettype none
// -----------------------------------------------------------------------------
// Register-level bench with open-drain line resolution
// -----------------------------------------------------------------------------
module test_master_two_wire_controller import mtw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  mtw_sfr_req_type sfr = '0;
  logic [7:0] rdata;
  logic [7:0] v;
  logic done, scl_o, scl_oe, sda_o, sda_oe, slv_oe, m_ack, stop_seen, addr_ack;
  logic [7:0] last_rx;
  wire logic scl_w = ~scl_oe;
  wire logic sda_w = ~(sda_oe | slv_oe);
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  time t_last = 0;
  time per = 0;
  mtw_ctrl dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_sfr(sfr),
    .o_sfr_rdata(rdata), .o_transfer_done(done), .i_bus_clock_line(scl_w),
    .o_bus_clock_line(scl_o), .o_bus_clock_line_oe(scl_oe), .i_bus_data_line(sda_w),
    .o_bus_data_line(sda_o), .o_bus_data_line_oe(sda_oe));
  mtw_slave_model #(.ADDR(7'h50)) slave (.i_scl(scl_w), .i_sda(sda_w), .o_sda_oe(slv_oe),
    .o_last_rx(last_rx), .o_master_ack(m_ack), .o_stop_seen(stop_seen),
    .o_addr_ack(addr_ack));
  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge scl_w) begin
    per = $time - t_last;
    t_last = $time;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    sfr <= '{a, 1'b1, 1'b0, d};
    @(posedge i_clk_sys);
    sfr.wr <= 1'b0;
  endtask
  // Read data stands for one cycle only, so it is taken just after the accepting edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    sfr <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge i_clk_sys);
    sfr.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_done();
    int k;
    for (k = 0; k < 20000; k++) begin
      @(posedge i_clk_sys);
      #1;
      if (done === 1'b1) break;
    end
    check("done flag", {7'h00, done}, 8'h01);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rd(8'hE1, v);
    check("ctrl reset", v, 8'h04);
    rd(8'hE3, v);
    check("unmapped read", v, 8'h00);
    wr(8'hE1, 8'h30);
    rd(8'hE1, v);
    check("ro bits", v, 8'h00);
    $display("test registers done");
    wr(8'hE2, 8'hA0);
    wr(8'hE1, 8'h88);
    wait_done();
    check("addr ack", {7'h00, addr_ack}, 8'h01);
    rd(8'hE1, v);
    check("ctrl after addr", v, 8'hA8);
    check("scl period rate0", 8'(per / 10), 8'd32);
    wr(8'hE1, 8'h88);
    wr(8'hE2, 8'h43);
    wait_done();
    check("tx byte", last_rx, 8'h43);
    rd(8'hE1, v);
    check("ctrl after data", v, 8'hA8);
    wr(8'hE1, 8'h84);
    idle(100);
    check("stop tx", {7'h00, stop_seen}, 8'h01);
    check("lines idle", {6'h00, scl_w, sda_w}, 8'h03);
    check("line drive level", {6'h00, scl_o, sda_o}, 8'h00);
    idle(300);
    wr(8'hE2, 8'hB0);
    wr(8'hE1, 8'h8A);
    wait_done();
    check("scl period rate2", 8'(per / 10), 8'd128);
    rd(8'hE1, v);
    check("nack in", v, 8'hBA);
    wr(8'hE1, 8'h84);
    idle(300);
    wr(8'hE2, 8'hA0);
    wr(8'hE1, 8'h8B);
    wait_done();
    // The slowest period is halved so that it still fits the byte-wide compare.
    check("scl period rate3", 8'(per / 20), 8'd128);
    wr(8'hE1, 8'h87);
    idle(600);
    $display("test transmit done");
    wr(8'hE2, 8'hA1);
    wr(8'hE1, 8'h89);
    wait_done();
    check("scl period rate1", 8'(per / 10), 8'd64);
    wr(8'hE1, 8'h89);
    rd(8'hE2, v);
    check("first read", v, 8'hA1);
    wait_done();
    check("master ack", {7'h00, m_ack}, 8'h00);
    wr(8'hE1, 8'hC9);
    rd(8'hE2, v);
    check("rx byte 1", v, 8'h25);
    wait_done();
    check("master nack", {7'h00, m_ack}, 8'h01);
    wr(8'hE1, 8'hC5);
    rd(8'hE2, v);
    check("rx byte 2", v, 8'hA6);
    idle(200);
    check("stop rx", {7'h00, stop_seen}, 8'h01);
    $display("test receive done");
    report_and_stop();
  end
endmodule
`default_nettype wire
